// *** common/ccr_pkg.sv ***
// Package with register map, field layout and carrier types of the comparator control block.
package ccr_pkg;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_CLEAR  = 4'hC;

  localparam int BIT_SEL   = 7;
  localparam int BIT_EN    = 6;
  localparam int BIT_POL   = 5;
  localparam int BIT_OUT   = 4;
  localparam int BIT_OS    = 3;
  localparam int BIT_HY    = 0;

  // Writable bits of the control register; result bit and bits 2..1 excluded.
  localparam logic [7:0] CTRL_WMASK = 8'hE9;
  localparam logic [7:0] CTRL_RESET = 8'h81;
  localparam logic [0:0] IRQ_CHANGE = 1'h0;

  typedef struct packed {
    logic       sel;
    logic       en;
    logic       pol;
    logic       os;
    logic       hy;
  } ccr_ctrl_t;

  typedef struct packed {
    ccr_ctrl_t  ctrl;
    logic       result;
    logic       irq_stat;
    logic       irq_en;
    logic       ack;
    logic [7:0] rdata;
    logic       irq;
    logic       pin_drive;
    logic       pin_oe;
    logic       wake;
  } ccr_state_t;
endpackage

// *** design/ccr_sync.sv ***
// Two-stage synchroniser for the asynchronous comparator output.
`timescale 1ns/1ps
module ccr_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= 1'h0;
      q_o  <= 1'h0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // ccr_sync

// *** design/ccr_top.sv ***
// Comparator control register block with Wishbone slave and change interrupt.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module ccr_top (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       comp_raw_i,
  input  wire logic       sleep_i,
  output logic            comparator_pin_select_o,
  output logic            comparator_power_on_o,
  output logic            hysteresis_enable_o,
  output logic            comparator_output_pin_o,
  output logic            comparator_output_pin_oe_o,
  output logic            irq_o,
  output logic            wake_o
);
  ccr_pkg::ccr_state_t st;
  ccr_pkg::ccr_state_t next_st;
  logic                raw_sync;
  logic                access;
  logic                lane0_wr;
  // Decodes and the expected next result, shared by the assertions below.
  logic                ctrl_wr;
  logic                clear_wr;
  logic                rd_req;
  logic                res_now;

  // The analog comparator output is asynchronous to clk_i.
  ccr_sync u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (comp_raw_i),
    .q_o       (raw_sync)
  );

  assign access   = wb_cyc_i && wb_stb_i && !st.ack;
  assign lane0_wr = access && wb_we_i && wb_sel_i[0];
  assign ctrl_wr  = lane0_wr && wb_adr_i == ccr_pkg::ADDR_CTRL;
  assign clear_wr = lane0_wr && wb_adr_i == ccr_pkg::ADDR_CLEAR
                    && wb_dat_i[ccr_pkg::IRQ_CHANGE];
  assign rd_req   = access && !wb_we_i;
  // The result the comparator path takes at the coming edge.
  assign res_now  = (st.ctrl.en & raw_sync) ^ st.ctrl.pol;

  function automatic logic [7:0] ctrl_byte(input ccr_pkg::ccr_ctrl_t c, input logic r);
    logic [7:0] b;
    b = 8'h00;
    b[ccr_pkg::BIT_SEL] = c.sel;
    b[ccr_pkg::BIT_EN]  = c.en;
    b[ccr_pkg::BIT_POL] = c.pol;
    b[ccr_pkg::BIT_OUT] = r;
    b[ccr_pkg::BIT_OS]  = c.os;
    b[ccr_pkg::BIT_HY]  = c.hy;
    return b;
  endfunction

  always_comb begin
    logic [7:0] wbyte;
    logic       new_res;
    logic       changed;
    wbyte   = 8'h00;
    next_st = st;
    next_st.ack = access;
    // A powered-down comparator presents a low raw result.
    new_res = (st.ctrl.en & raw_sync) ^ st.ctrl.pol;
    changed = new_res != st.result;
    next_st.result = new_res;
    // Read data is captured once per access and held, since the bus only looks while ack stands.
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        ccr_pkg::ADDR_CTRL:   next_st.rdata = ctrl_byte(st.ctrl, st.result);
        ccr_pkg::ADDR_STATUS: next_st.rdata = {7'h00, st.irq_stat};
        ccr_pkg::ADDR_ENABLE: next_st.rdata = {7'h00, st.irq_en};
        default:              next_st.rdata = 8'h00;
      endcase
    end
    if (lane0_wr && wb_adr_i == ccr_pkg::ADDR_CTRL) begin
      // Only writable positions are taken; result and unused bits ignored.
      wbyte = wb_dat_i[7:0] & ccr_pkg::CTRL_WMASK;
      next_st.ctrl.sel = wbyte[ccr_pkg::BIT_SEL];
      next_st.ctrl.en  = wbyte[ccr_pkg::BIT_EN];
      next_st.ctrl.pol = wbyte[ccr_pkg::BIT_POL];
      next_st.ctrl.os  = wbyte[ccr_pkg::BIT_OS];
      next_st.ctrl.hy  = wbyte[ccr_pkg::BIT_HY];
    end
    if (lane0_wr && wb_adr_i == ccr_pkg::ADDR_ENABLE) begin
      next_st.irq_en = wb_dat_i[ccr_pkg::IRQ_CHANGE];
    end
    if (lane0_wr && wb_adr_i == ccr_pkg::ADDR_CLEAR && wb_dat_i[ccr_pkg::IRQ_CHANGE]) begin
      next_st.irq_stat = 1'h0;
    end
    // Set wins over a clear in the same cycle.
    if (changed) begin
      next_st.irq_stat = 1'h1;
    end
    next_st.irq  = next_st.irq_stat & next_st.irq_en;
    next_st.wake = next_st.irq_stat & sleep_i & st.ctrl.en;
    next_st.pin_drive = new_res;
    next_st.pin_oe    = next_st.ctrl.sel & ~next_st.ctrl.os;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // Everything clears except the fields whose power-on value is one.
      st          <= '0;
      st.ctrl.sel <= ccr_pkg::CTRL_RESET[ccr_pkg::BIT_SEL];
      st.ctrl.hy  <= ccr_pkg::CTRL_RESET[ccr_pkg::BIT_HY];
      st.pin_oe   <= ccr_pkg::CTRL_RESET[ccr_pkg::BIT_SEL];
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o                   = {24'h000000, st.rdata};
  assign wb_ack_o                   = st.ack;
  assign comparator_pin_select_o    = st.ctrl.sel;
  assign comparator_power_on_o      = st.ctrl.en;
  assign hysteresis_enable_o        = st.ctrl.hy;
  assign comparator_output_pin_o    = st.pin_drive;
  assign comparator_output_pin_oe_o = st.pin_oe;
  assign irq_o                      = st.irq;
  assign wake_o                     = st.wake;

  // Reset values of the select, power and hysteresis fields and of every output except wb_dat_o.
  a_reset_select: assert property (@(posedge clk_i)
    sys_rst_i |=> comparator_pin_select_o && !comparator_power_on_o)
    else $error("pin select or power bit wrong after reset");
  a_reset_outputs: assert property (@(posedge clk_i)
    sys_rst_i |=> hysteresis_enable_o && comparator_output_pin_oe_o && !comparator_output_pin_o
      && !irq_o && !wake_o && !wb_ack_o)
    else $error("outputs wrong after reset");

  // Result path.
  a_power_off_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !st.ctrl.en && !st.ctrl.pol && !$past(sys_rst_i) |=> !st.result)
    else $error("result high while comparator off");
  a_polarity_inv: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(st.ctrl) && $stable(raw_sync) && !$past(sys_rst_i)
      |-> st.result == ((st.ctrl.en & raw_sync) ^ st.ctrl.pol))
    else $error("polarity not applied");
  a_result_reads: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    access && !wb_we_i && wb_adr_i == ccr_pkg::ADDR_CTRL
      |=> wb_dat_o[ccr_pkg::BIT_OUT] == $past(st.result))
    else $error("result bit read wrong");
  a_route_pin: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 comparator_output_pin_oe_o == (st.ctrl.sel && !st.ctrl.os))
    else $error("output pin routing wrong");
  a_pin_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    comparator_output_pin_o == st.result)
    else $error("output pin does not follow result");

  // Register writes land on the edge that takes the request.
  a_sel_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr |=> comparator_pin_select_o == $past(wb_dat_i[ccr_pkg::BIT_SEL]))
    else $error("pin select write lost");
  a_power_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr |=> comparator_power_on_o == $past(wb_dat_i[ccr_pkg::BIT_EN]))
    else $error("power write lost");
  a_pol_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr |=> st.ctrl.pol == $past(wb_dat_i[ccr_pkg::BIT_POL]))
    else $error("polarity write lost");
  a_route_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr |=> st.ctrl.os == $past(wb_dat_i[ccr_pkg::BIT_OS]))
    else $error("route write lost");
  a_hyst_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_wr |=> hysteresis_enable_o == $past(wb_dat_i[ccr_pkg::BIT_HY]))
    else $error("hysteresis write lost");
  a_lane_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    access && wb_we_i && !wb_sel_i[0] |=> $stable(st.ctrl) && $stable(st.irq_en))
    else $error("write without lane zero changed a register");

  // Change flag, interrupt and wake-up.
  a_change_sets: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(st.result) && !$past(sys_rst_i) |-> st.irq_stat)
    else $error("change did not set flag");
  a_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_wr && st.result != res_now |=> st.irq_stat)
    else $error("clear beat a change in the same cycle");
  a_flag_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clear_wr && st.result == res_now |=> !st.irq_stat)
    else $error("flag not cleared");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.irq_stat && !clear_wr |=> st.irq_stat)
    else $error("flag dropped without clear");
  a_enable_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lane0_wr && wb_adr_i == ccr_pkg::ADDR_ENABLE
      |=> st.irq_en == $past(wb_dat_i[ccr_pkg::IRQ_CHANGE]))
    else $error("enable write lost");
  a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o == (st.irq_stat && st.irq_en))
    else $error("interrupt level wrong");
  a_wake_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i)
      |-> wake_o == (st.irq_stat && $past(sleep_i) && $past(st.ctrl.en)))
    else $error("wake level wrong");

  // Bus reads and handshake.
  a_status_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_req && wb_adr_i == ccr_pkg::ADDR_STATUS |=> wb_dat_o == {31'h0, $past(st.irq_stat)})
    else $error("status read wrong");
  a_enable_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_req && wb_adr_i == ccr_pkg::ADDR_ENABLE |=> wb_dat_o == {31'h0, $past(st.irq_en)})
    else $error("enable read wrong");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_req && wb_adr_i != ccr_pkg::ADDR_CTRL && wb_adr_i != ccr_pkg::ADDR_STATUS
      && wb_adr_i != ccr_pkg::ADDR_ENABLE |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_unused_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |-> wb_dat_o[2:1] == 2'h0 && wb_dat_o[31:8] == 24'h000000)
    else $error("unused bits not zero");
  a_ack_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    access |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_write_ctrl:      cover property (@(posedge clk_i) ctrl_wr);
  c_irq_fire:        cover property (@(posedge clk_i) $rose(irq_o));
  c_wake:            cover property (@(posedge clk_i) $rose(wake_o));
  c_clear_set:       cover property (@(posedge clk_i) lane0_wr && wb_adr_i == ccr_pkg::ADDR_CLEAR);
  c_set_over_clear:  cover property (@(posedge clk_i) clear_wr && st.result != res_now);
endmodule // ccr_top

// *** bench/ccr_analog.sv ***
// Behavioural analog comparator that stands on the shared input pins.
`timescale 1ns/1ps
module ccr_analog (
  input  wire logic power_on_i,
  input  wire logic pos_gt_i,
  output logic      comp_raw_o
);
  // A powered-down comparator draws nothing, so its output rests low.
  assign comp_raw_o = power_on_i & pos_gt_i;
endmodule // ccr_analog

// *** bench/tb.sv ***
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
module tb;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc       = 1'b0;
  logic        we        = 1'b0;
  logic [3:0]  adr       = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  lanes     = 4'hF;
  logic        sleep     = 1'b0;
  logic        pos_gt    = 1'b0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack, raw, sel_o, pwr_o, hy_o, pin_o, oe_o, irq, wake;
  int          errors     = 0;
  int          num_checks = 0;

  ccr_analog ana_u (.power_on_i(pwr_o), .pos_gt_i(pos_gt), .comp_raw_o(raw));
  ccr_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(lanes), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .comp_raw_i(raw), .sleep_i(sleep), .comparator_pin_select_o(sel_o),
    .comparator_power_on_o(pwr_o), .hysteresis_enable_o(hy_o),
    .comparator_output_pin_o(pin_o), .comparator_output_pin_oe_o(oe_o), .irq_o(irq),
    .wake_o(wake));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic results();
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled high, then idles one cycle.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      errors++;
      results();
    end else begin
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(q, {24'h0, exp});
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ccr_pkg::ADDR_CTRL, 8'h81);
    chk({27'h0, sel_o, pwr_o, hy_o, oe_o, pin_o}, 32'h16);
    acc(1'b1, ccr_pkg::ADDR_CTRL, 8'hFF);
    repeat (5) @(posedge clk_i);
    rd(ccr_pkg::ADDR_CTRL, 8'hF9);
    chk({28'h0, sel_o, pwr_o, hy_o, oe_o}, 32'hE);
    rd(ccr_pkg::ADDR_STATUS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, ccr_pkg::ADDR_ENABLE, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, wake}, 32'h1);
    sleep <= 1'b0;
    acc(1'b1, ccr_pkg::ADDR_CLEAR, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rd(ccr_pkg::ADDR_STATUS, 8'h00);
    rd(ccr_pkg::ADDR_CLEAR, 8'h00);
    pos_gt <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    rd(ccr_pkg::ADDR_CTRL, 8'hE9);
    acc(1'b1, 4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    acc(1'b1, ccr_pkg::ADDR_CTRL, 8'h40);
    repeat (5) @(posedge clk_i);
    rd(ccr_pkg::ADDR_CTRL, 8'h50);
    chk({28'h0, sel_o, pwr_o, hy_o, oe_o}, 32'h4);
    acc(1'b1, ccr_pkg::ADDR_CTRL, 8'h80);
    repeat (5) @(posedge clk_i);
    rd(ccr_pkg::ADDR_CTRL, 8'h80);
    chk({27'h0, sel_o, pwr_o, hy_o, oe_o, pin_o}, 32'h12);
    sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, wake}, 32'h0);
    sleep <= 1'b0;
    lanes <= 4'hE;
    acc(1'b1, ccr_pkg::ADDR_CTRL, 8'h00);
    lanes <= 4'hF;
    rd(ccr_pkg::ADDR_CTRL, 8'h80);
    acc(1'b1, ccr_pkg::ADDR_CTRL, 8'hC0);
    repeat (5) @(posedge clk_i);
    chk({27'h0, sel_o, pwr_o, hy_o, oe_o, pin_o}, 32'h1B);
    results();
  end
endmodule // tb
